// ==== tamo_pkg.sv ====
// package: offsets, field layouts and reset values of the alarm/offset bank
package tamo_pkg;
	localparam logic [6:0] ADDR_TEMP = 7'h06;
	localparam logic [6:0] ADDR_MASK = 7'h07;
	localparam logic [6:0] ADDR_OFFA = 7'h08;
	localparam logic [6:0] ADDR_OFFB = 7'h09;
	localparam int TEMP_LSB = 8;
	localparam int OFFSET_W = 13;
	localparam logic [15:0] MASK_RESET = 16'hFFFF;
	localparam logic [15:0] OFFA_RESET = 16'h0000;
	localparam logic [15:0] OFFB_RESET = 16'h0000;
	localparam logic [15:0] MASK_USED = 16'hBFBC;
	localparam int BIT_FIFO_COLL = 13;
	localparam int BIT_FIFO_ONE = 12;
	localparam int BIT_FIFO_TWO = 11;
	localparam int TEMP_READ_NS = 1000;
	localparam int CLK_NS = 10;
	localparam int TEMP_READ_CYC = (TEMP_READ_NS + CLK_NS - 1) / CLK_NS;
endpackage : tamo_pkg

// ==== tamo_sync_if.sv ====
// interface: offset pair handed to the correction block on auto-sync
`timescale 1ns/100ps
`default_nettype none
interface tamo_sync_if;
	logic load;
	logic [12:0] off_a;
	logic [12:0] off_b;
	logic [12:0] act_a;
	logic [12:0] act_b;
	modport src (output load, output off_a, output off_b);
	modport dst (input load, input off_a, input off_b,
		output act_a, output act_b);
endinterface : tamo_sync_if
`default_nettype wire

// ==== tamo_offset_hold.sv ====
// module: active offset pair, loaded together on auto-sync
`timescale 1ns/100ps
`default_nettype none
module tamo_offset_hold (
	input wire logic core_clk,
	input wire logic reset_n,
	tamo_sync_if.dst sync
);
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync.act_a <= 13'h0000;
			sync.act_b <= 13'h0000;
		end else if (sync.load) begin
			sync.act_a <= sync.off_a;
			sync.act_b <= sync.off_b;
		end
	end
endmodule : tamo_offset_hold
`default_nettype wire

// ==== tamo_regs.sv ====
// module: temperature, alarm mask and A/B offset register bank
`timescale 1ns/100ps
`default_nettype none
module tamo_regs (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic auto_sync_en,
	input wire logic [7:0] temp_sensor,
	input wire logic [15:0] alarm_status,
	input wire logic [2:0] fifo_status,
	output logic alarm_out,
	output logic [15:0] alarm_word,
	output logic [12:0] chan_a_offset_value,
	output logic [12:0] chan_b_offset_value,
	output logic sync_pulse
);
	logic [15:0] mask_q;
	logic [12:0] offa_q;
	logic [12:0] offb_q;
	logic [7:0] temp_q;
	logic sync_q;
	logic boot_q;
	logic [15:0] status_w;
	logic [15:0] gated_w;
	tamo_sync_if sif ();

	function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
		hit = (a == b);
	endfunction : hit

	// sensor sampled every cycle; no reset constant is meaningful here
	always_ff @(posedge core_clk) begin
		temp_q <= temp_sensor;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_q <= tamo_pkg::MASK_RESET;
		end else if (reg_wr && hit(reg_addr, tamo_pkg::ADDR_MASK)) begin
			mask_q <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			offa_q <= tamo_pkg::OFFA_RESET[12:0];
			offb_q <= tamo_pkg::OFFB_RESET[12:0];
		end else if (reg_wr) begin
			if (hit(reg_addr, tamo_pkg::ADDR_OFFA)) begin
				offa_q <= reg_wdata[12:0];
			end
			if (hit(reg_addr, tamo_pkg::ADDR_OFFB)) begin
				offb_q <= reg_wdata[12:0];
			end
		end
	end

	// reset load is a sync of its own, issued once just after release
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_q <= 1'b1;
			sync_q <= 1'b0;
		end else begin
			boot_q <= 1'b0;
			sync_q <= boot_q
				|| (reg_wr && auto_sync_en
				&& hit(reg_addr, tamo_pkg::ADDR_OFFA));
		end
	end

	assign sif.load = sync_q;
	assign sif.off_a = offa_q;
	assign sif.off_b = offb_q;

	tamo_offset_hold u_hold (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.sync(sif)
	);

	// fifo field decoded by priority: collision beats one-apart beats two
	always_comb begin
		status_w = alarm_status & tamo_pkg::MASK_USED;
		status_w[tamo_pkg::BIT_FIFO_COLL] = fifo_status[2];
		status_w[tamo_pkg::BIT_FIFO_ONE] = !fifo_status[2]
			&& fifo_status[1];
		status_w[tamo_pkg::BIT_FIFO_TWO] = fifo_status == 3'b001;
	end

	// one gate per alarm, so a masked bit never reaches alarm_out; alarm_word still carries status_w unmasked
	for (genvar i = 0; i < 16; i++) begin : g_gate
		assign gated_w[i] = status_w[i] && !mask_q[i];
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			alarm_word <= 16'h0000;
			alarm_out <= 1'b0;
		end else begin
			alarm_word <= status_w;
			alarm_out <= |gated_w;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				tamo_pkg::ADDR_TEMP: reg_rdata <= {temp_q, 8'h00};
				tamo_pkg::ADDR_MASK: reg_rdata <= mask_q;
				tamo_pkg::ADDR_OFFA: reg_rdata <= {3'h0, offa_q};
				tamo_pkg::ADDR_OFFB: reg_rdata <= {3'h0, offb_q};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_a_offset_value <= 13'h0000;
			chan_b_offset_value <= 13'h0000;
			sync_pulse <= 1'b0;
		end else begin
			chan_a_offset_value <= sif.act_a;
			chan_b_offset_value <= sif.act_b;
			sync_pulse <= sync_q;
		end
	end
endmodule : tamo_regs
`default_nettype wire

// ==== tamo_regs_assertions.sv ====
// checker: register bank timing and decode, bound to tamo_regs
`timescale 1ns/100ps
`default_nettype none
module tamo_regs_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic auto_sync_en,
	input wire logic [7:0] temp_sensor,
	input wire logic [15:0] alarm_status,
	input wire logic [2:0] fifo_status,
	input wire logic alarm_out,
	input wire logic [15:0] alarm_word,
	input wire logic [12:0] chan_a_offset_value,
	input wire logic [12:0] chan_b_offset_value,
	input wire logic sync_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire wa = reg_wr && reg_addr == 7'h08 && auto_sync_en;
	property p_temp; reg_rd && reg_addr == 7'h06 && $stable(temp_sensor)
		|=> reg_rdata == {$past(temp_sensor), 8'h00}; endproperty
	a_temp: assert property (p_temp) else $error("temp");
	property p_resv; reg_rd && reg_addr[6:1] == 6'h04
		|=> reg_rdata[15:13] == 3'h0; endproperty
	a_resv: assert property (p_resv) else $error("resv");
	property p_sync; wa |=> ##1 sync_pulse; endproperty
	a_sync: assert property (p_sync) else $error("sync");
	property p_load; wa
		|=> ##2 chan_a_offset_value == $past(reg_wdata[12:0], 3); endproperty
	a_load: assert property (p_load) else $error("load");
	property p_hold; $changed(chan_a_offset_value) ||
		$changed(chan_b_offset_value) |-> $past(sync_pulse); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_out; alarm_out |-> alarm_word != 16'h0000; endproperty
	a_out: assert property (p_out) else $error("out");
	property p_word; $past(reset_n)
		|-> (alarm_word & 16'h47FF) == ($past(alarm_status) & 16'h07BC);
	endproperty
	a_word: assert property (p_word) else $error("word");
	property p_fifo; $past(reset_n)
		|-> alarm_word[13] == $past(fifo_status[2]); endproperty
	a_fifo: assert property (p_fifo) else $error("fifo");
	cover property (wa);
	cover property (sync_pulse);
	cover property (alarm_out);
endmodule : tamo_regs_chk
bind tamo_regs tamo_regs_chk u_tamo_regs_chk (.*);
`default_nettype wire

// ==== test_tamo_regs.sv ====
// testbench: register bank reads, writes, offsets and alarms
`timescale 1ns/100ps
`default_nettype none
module test_tamo_regs;
	logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
	logic auto_sync_en = 0, alarm_out, sync_pulse;
	logic [6:0] reg_addr = 0;
	logic [7:0] temp_sensor = 8'hE7;
	logic [2:0] fifo_status = 0;
	logic [12:0] chan_a_offset_value, chan_b_offset_value;
	logic [15:0] reg_wdata = 0, reg_rdata, alarm_status = 0, alarm_word;
	int n_mismatch = 0, checks = 0;
	tamo_regs u_tamo_regs (.*);
	initial forever #5 core_clk = ~core_clk;
	task chk(logic [15:0] g, logic [15:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %0t %h %h", $time, g, e);
		end
	endtask : chk
	task wr(logic [6:0] a, logic [15:0] d);
		@(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge core_clk) reg_wr = 0;
	endtask : wr
	task rd(logic [6:0] a, logic [15:0] e);
		@(negedge core_clk) {reg_rd, reg_addr} = {1'b1, a};
		@(negedge core_clk) reg_rd = 0;
		chk(reg_rdata, e);
	endtask : rd
	task summarize;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (10) @(negedge core_clk);
		reset_n = 1;
		repeat (2) @(negedge core_clk);
		chk({15'h0, sync_pulse}, 16'h0001);
		repeat (2) @(negedge core_clk);
		rd(7'h07, 16'hFFFF);
		chk({3'h0, chan_a_offset_value}, 16'h0000);
		rd(7'h06, 16'hE700);
		wr(7'h06, 16'h1234);
		rd(7'h06, 16'hE700);
		rd(7'h20, 16'h0000);
		auto_sync_en = 1;
		wr(7'h09, 16'hFFFF);
		repeat (3) @(negedge core_clk);
		chk({3'h0, chan_b_offset_value}, 16'h0000);
		rd(7'h09, 16'h1FFF);
		wr(7'h08, 16'hE123);
		@(negedge core_clk);
		chk({15'h0, sync_pulse}, 16'h0001);
		repeat (2) @(negedge core_clk);
		chk({3'h0, chan_a_offset_value}, 16'h0123);
		chk({3'h0, chan_b_offset_value}, 16'h1FFF);
		auto_sync_en = 0;
		wr(7'h08, 16'h0005);
		@(negedge core_clk);
		chk({15'h0, sync_pulse}, 16'h0000);
		repeat (2) @(negedge core_clk);
		chk({3'h0, chan_a_offset_value}, 16'h0123);
		rd(7'h08, 16'h0005);
		alarm_status = 16'h4401;
		repeat (2) @(negedge core_clk);
		chk({15'h0, alarm_out}, 16'h0000);
		chk(alarm_word, 16'h0400);
		wr(7'h07, 16'hFBFF);
		repeat (2) @(negedge core_clk);
		chk({15'h0, alarm_out}, 16'h0001);
		alarm_status = 0;
		for (int i = 0; i < 8; i++) begin
			fifo_status = i[2:0];
			repeat (2) @(negedge core_clk);
			chk(alarm_word, {2'h0, i[2], i[2:1] == 2'h1, i == 1, 11'h0});
		end
		summarize();
	end
endmodule : test_tamo_regs
`default_nettype wire
